// ===== rtl/awd_area_wait_decode.sv
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "awd_params.svh"
module awd_area_wait_decode
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Access request
  input  wire logic        acc_req,
  input  wire logic [2:0]  acc_area,
  input  wire logic [2:0]  acc_extra_beats,
  output logic             acc_busy,
  output logic             beat_strobe,
  output logic             acc_done,
  // Pins
  input  wire logic        ext_ready_n,
  input  wire logic        manual_reset_n
);
  import awd_pkg::*;

  awd_seq_if sif ();

  logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] wait_q, wait_d, mode_q, mode_d;
  logic        rdy_s1_q, rdy_s2_q, mrst_s1_q, mrst_s2_q;
  logic        start_q, start_d, frdy_q, frdy_d, prdy_q, prdy_d;
  awd_wait_type fw_q, fw_d, pw_q, pw_d;
  logic [2:0]  eb_q, eb_d;
  logic [2:0]  c5, c4, c3, c2;
  awd_mem_type m2, m3;
  logic        a2_bad, a3_bad, take;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign c5 = wait_q[`AWD_A5W_HI:`AWD_A5W_LO];
  assign c4 = wait_q[`AWD_A4W_HI:`AWD_A4W_LO];
  assign c3 = wait_q[`AWD_A3W_HI:`AWD_A3W_LO];
  assign c2 = wait_q[`AWD_A2W_HI:`AWD_A2W_LO];
  assign m2 = awd_mem_type'(mode_q[`AWD_M2_HI:`AWD_M2_LO]);
  assign m3 = awd_mem_type'(mode_q[`AWD_M3_HI:`AWD_M3_LO]);
  assign a2_bad = (m2 == awd_sdram) && awd_sdram_bad(c2, mode_q[`AWD_ROW_OPEN]);
  assign a3_bad = (m3 == awd_sdram) && awd_sdram_bad(c3, mode_q[`AWD_ROW_OPEN]);

  // Register bus and register file
  always_comb
  begin
    aw_hold_d = aw_hold_q | (awvalid & awready_q);
    w_hold_d  = w_hold_q | (wvalid & wready_q);
    awaddr_d  = (awvalid && awready_q) ? awaddr : awaddr_q;
    wdata_d   = (wvalid && wready_q) ? wdata : wdata_q;
    wstrb_d   = (wvalid && wready_q) ? wstrb : wstrb_q;
    bvalid_d  = bvalid_q && !bready;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q && !rready;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    wait_d    = wait_q;
    mode_d    = mode_q;
    if (aw_hold_q && w_hold_q && !bvalid_q)
    begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `AWD_RESP_OKAY;
      if (awaddr_q == `AWD_OFS_WAIT)
      begin
        wait_d = merge(wait_q, wdata_q, wstrb_q) & `AWD_WAIT_WMASK;
      end
      else if (awaddr_q == `AWD_OFS_MODE)
      begin
        mode_d = merge(mode_q, wdata_q, wstrb_q) & `AWD_MODE_WMASK;
      end
      else if (awaddr_q != `AWD_OFS_STAT)
      begin
        bresp_d = `AWD_RESP_SLVERR;
      end
    end
    if (arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = `AWD_RESP_OKAY;
      rdata_d  = 32'h00000000;
      if (araddr == `AWD_OFS_WAIT)
      begin
        rdata_d = wait_q;
      end
      else if (araddr == `AWD_OFS_MODE)
      begin
        rdata_d = mode_q;
      end
      else if (araddr == `AWD_OFS_STAT)
      begin
        rdata_d[`AWD_ST_BUSY]   = sif.busy;
        rdata_d[`AWD_ST_READY]  = !rdy_s2_q;
        rdata_d[`AWD_ST_A2_BAD] = a2_bad;
        rdata_d[`AWD_ST_A3_BAD] = a3_bad;
      end
      else
      begin
        rresp_d = `AWD_RESP_SLVERR;
      end
    end
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d  = !w_hold_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `AWD_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= `AWD_RESP_OKAY;
      rdata_q   <= 32'h00000000;
      wait_q    <= `AWD_WAIT_RESET;
      mode_q    <= `AWD_MODE_RESET;
    end
    else
    begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      arready_q <= arready_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      wait_q    <= wait_d;
      mode_q    <= mode_d;
    end
  end

  // Pin synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdy_s1_q  <= 1'b1;
      rdy_s2_q  <= 1'b1;
      mrst_s1_q <= 1'b1;
      mrst_s2_q <= 1'b1;
    end
    else
    begin
      rdy_s1_q  <= ext_ready_n;
      rdy_s2_q  <= rdy_s1_q;
      mrst_s1_q <= manual_reset_n;
      mrst_s2_q <= mrst_s1_q;
    end
  end

  // Access decode per area
  always_comb
  begin
    take    = acc_req && !sif.busy && !start_q && mrst_s2_q &&
              acc_area >= 3'h2 && acc_area <= 3'h5;
    start_d = take;
    fw_d    = fw_q;
    frdy_d  = frdy_q;
    pw_d    = pw_q;
    prdy_d  = prdy_q;
    eb_d    = eb_q;
    if (take)
    begin
      pw_d   = 4'h0;
      prdy_d = 1'b0;
      eb_d   = 3'h0;
      if (acc_area == 3'h5)
      begin
        fw_d   = awd_first_waits(c5);
        frdy_d = c5 != 3'h0;
        pw_d   = {1'b0, wait_q[`AWD_A5B_HI:`AWD_A5B_LO]};
        prdy_d = wait_q[`AWD_A5B_HI:`AWD_A5B_LO] != 3'h0;
        eb_d   = acc_extra_beats;
      end
      else if (acc_area == 3'h4)
      begin
        fw_d   = awd_first_waits(c4);
        frdy_d = c4 != 3'h0;
      end
      else if (acc_area == 3'h3)
      begin
        fw_d   = awd_area_waits(c3, m3);
        frdy_d = awd_area_rdy(c3, m3);
      end
      else
      begin
        fw_d   = awd_area_waits(c2, m2);
        frdy_d = awd_area_rdy(c2, m2);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_q <= 1'b0;
      fw_q    <= 4'h0;
      frdy_q  <= 1'b0;
      pw_q    <= 4'h0;
      prdy_q  <= 1'b0;
      eb_q    <= 3'h0;
    end
    else
    begin
      start_q <= start_d;
      fw_q    <= fw_d;
      frdy_q  <= frdy_d;
      pw_q    <= pw_d;
      prdy_q  <= prdy_d;
      eb_q    <= eb_d;
    end
  end

  assign sif.start        = start_q;
  assign sif.first_waits  = fw_q;
  assign sif.first_rdy_en = frdy_q;
  assign sif.pitch_waits  = pw_q;
  assign sif.pitch_rdy_en = prdy_q;
  assign sif.extra_beats  = eb_q;
  assign sif.ready_ok     = !rdy_s2_q;
  assign sif.abort        = !mrst_s2_q;

  awd_wait_seq u_seq
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sif     (sif)
  );

  assign awready     = awready_q;
  assign wready      = wready_q;
  assign bvalid      = bvalid_q;
  assign bresp       = bresp_q;
  assign arready     = arready_q;
  assign rvalid      = rvalid_q;
  assign rresp       = rresp_q;
  assign rdata       = rdata_q;
  assign acc_busy    = sif.busy;
  assign beat_strobe = sif.beat;
  assign acc_done    = sif.done;

  sequence s_take_a5_zero;
    take && acc_area == 3'h5 && c5 == 3'h0 && wait_q[`AWD_A5B_HI:`AWD_A5B_LO] == 3'h0;
  endsequence

  a_reset_value: assert property (@(posedge aclk)
    ($past(aresetn) == 1'b0 && aresetn) |-> wait_q == `AWD_WAIT_RESET)
    else $error("wait control not at default after reset");
  a_manual_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (!mrst_s2_q && !(aw_hold_q && w_hold_q)) |=> $stable(wait_q))
    else $error("manual reset changed wait control");
  a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_q |-> rdata_q[`AWD_RSVD_A] == 1'b0 && rdata_q[`AWD_RSVD_B] == 1'b0)
    else $error("reserved bit read as one");
  a_a5_zero_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_take_a5_zero ##0 acc_extra_beats == 3'h0 ##1 mrst_s2_q [*2]) |=> beat_strobe)
    else $error("area 5 zero wait not immediate");
  a_pitch_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_take_a5_zero ##0 acc_extra_beats == 3'h1 ##1 mrst_s2_q [*3]) |-> beat_strobe [*2])
    else $error("area 5 zero pitch beats not back to back");
  a_a4_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && acc_area == 3'h4) |=> fw_q == (($past(c4) < 3'h4) ? {1'b0, $past(c4)}
                                            : 4'(3 * $past(c4) - 6))
                                 && frdy_q == ($past(c4) != 3'h0))
    else $error("area 4 waits misdecoded");
  a_a3_sram_max: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && acc_area == 3'h3 && m3 == awd_sram && c3 == 3'h7) |=> fw_q == 4'hf && frdy_q)
    else $error("area 3 sram waits misdecoded");
  a_a2_sram_six: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && acc_area == 3'h2 && m2 == awd_sram && c2 == 3'h4) |=> fw_q == 4'h6 && frdy_q)
    else $error("area 2 sram waits misdecoded");
  a_dram_width: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && acc_area == 3'h2 && m2 == awd_dram && c2 == 3'h7) |=> fw_q == 4'hf && !frdy_q)
    else $error("dram cas width misdecoded");
  a_sdram_lat: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && acc_area == 3'h3 && m3 == awd_sdram && c3 == 3'h3) |=> fw_q == 4'h3 && !frdy_q)
    else $error("sdram latency misdecoded");
  a_row_open_bad: assert property (@(posedge aclk) disable iff (!aresetn)
    (m3 == awd_sdram && mode_q[`AWD_ROW_OPEN] && c3 == 3'h4) |-> a3_bad)
    else $error("row-open latency not flagged");

endmodule

// ===== rtl/awd_params.svh
`ifndef AWD_PARAMS_SVH
`define AWD_PARAMS_SVH

// Register byte offsets
`define AWD_OFS_WAIT       8'h00
`define AWD_OFS_MODE       8'h04
`define AWD_OFS_STAT       8'h08

// Reset values and writable masks
`define AWD_WAIT_RESET     32'hfffeefff
`define AWD_WAIT_WMASK     32'hfffeefff
`define AWD_MODE_RESET     32'h00000000
`define AWD_MODE_WMASK     32'h0000001f

// Wait control field positions
`define AWD_A5W_HI         25
`define AWD_A5W_LO         23
`define AWD_A5B_HI         22
`define AWD_A5B_LO         20
`define AWD_A4W_HI         19
`define AWD_A4W_LO         17
`define AWD_A3W_HI         15
`define AWD_A3W_LO         13
`define AWD_A2W_HI         11
`define AWD_A2W_LO         9
`define AWD_RSVD_A         16
`define AWD_RSVD_B         12

// Mode field positions
`define AWD_M2_HI          1
`define AWD_M2_LO          0
`define AWD_M3_HI          3
`define AWD_M3_LO          2
`define AWD_ROW_OPEN       4

// Status bit positions
`define AWD_ST_BUSY        0
`define AWD_ST_READY       1
`define AWD_ST_A2_BAD      2
`define AWD_ST_A3_BAD      3

// Bus responses
`define AWD_RESP_OKAY      2'b00
`define AWD_RESP_SLVERR    2'b10

`endif

// ===== rtl/awd_pkg.sv
package awd_pkg;

  typedef enum logic [1:0] {awd_sram, awd_mpx, awd_dram, awd_sdram} awd_mem_type;
  typedef enum logic [0:0] {awd_idle, awd_wait} awd_state_type;
  typedef logic [3:0] awd_wait_type;

  // Code to first-cycle waits: 0,1,2,3,6,9,12,15
  function automatic awd_wait_type awd_first_waits(input logic [2:0] code);
    awd_wait_type w;
    w = 4'h0;
    case (code)
      3'h0: w = 4'h0;
      3'h1: w = 4'h1;
      3'h2: w = 4'h2;
      3'h3: w = 4'h3;
      3'h4: w = 4'h6;
      3'h5: w = 4'h9;
      3'h6: w = 4'hc;
      default: w = 4'hf;
    endcase
    return w;
  endfunction

  // Waits for area 2 or 3 by memory kind
  function automatic awd_wait_type awd_area_waits(input logic [2:0] code,
                                                  input awd_mem_type mem);
    awd_wait_type w;
    w = awd_first_waits(code);
    if (mem == awd_sdram)
    begin
      w = {1'b0, code};
    end
    return w;
  endfunction

  // Ready input honoured only for SRAM or multiplexed, nonzero code
  function automatic logic awd_area_rdy(input logic [2:0] code, input awd_mem_type mem);
    return (code != 3'h0) && (mem == awd_sram || mem == awd_mpx);
  endfunction

  // SDRAM latency code not allowed
  function automatic logic awd_sdram_bad(input logic [2:0] code, input logic row_open);
    return (code == 3'h0) || (code > 3'h5) ||
           (row_open && (code == 3'h1 || code == 3'h4 || code == 3'h5));
  endfunction

endpackage

// ===== rtl/awd_seq_if.sv
`timescale 1ns/10ps
interface awd_seq_if;
  import awd_pkg::*;
  logic         start;
  awd_wait_type first_waits;
  logic         first_rdy_en;
  awd_wait_type pitch_waits;
  logic         pitch_rdy_en;
  logic [2:0]   extra_beats;
  logic         ready_ok;
  logic         abort;
  logic         busy;
  logic         beat;
  logic         done;

  modport ctl (output start, first_waits, first_rdy_en, pitch_waits, pitch_rdy_en,
               extra_beats, ready_ok, abort, input busy, beat, done);
  modport seq (input start, first_waits, first_rdy_en, pitch_waits, pitch_rdy_en,
               extra_beats, ready_ok, abort, output busy, beat, done);
endinterface

// ===== rtl/awd_wait_seq.sv
`timescale 1ns/10ps
module awd_wait_seq
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control carrier
  awd_seq_if.seq   sif
);
  import awd_pkg::*;

  awd_state_type state_q, state_d;
  awd_wait_type  cnt_q, cnt_d;
  awd_wait_type  pitch_q, pitch_d;
  logic          rdy_en_q, rdy_en_d;
  logic          prdy_q, prdy_d;
  logic [2:0]    beats_q, beats_d;
  logic          busy_q, busy_d;
  logic          beat_q, beat_d;
  logic          done_q, done_d;

  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    pitch_d  = pitch_q;
    rdy_en_d = rdy_en_q;
    prdy_d   = prdy_q;
    beats_d  = beats_q;
    busy_d   = busy_q;
    beat_d   = 1'b0;
    done_d   = 1'b0;
    case (state_q)
      awd_idle:
      begin
        if (sif.start && !sif.abort)
        begin
          state_d  = awd_wait;
          cnt_d    = sif.first_waits;
          rdy_en_d = sif.first_rdy_en;
          pitch_d  = sif.pitch_waits;
          prdy_d   = sif.pitch_rdy_en;
          beats_d  = sif.extra_beats;
          busy_d   = 1'b1;
        end
      end
      awd_wait:
      begin
        if (cnt_q != 4'h0)
        begin
          cnt_d = cnt_q - 4'h1;
        end
        else if (!rdy_en_q || sif.ready_ok)
        begin
          beat_d = 1'b1;
          if (beats_q == 3'h0)
          begin
            state_d = awd_idle;
            busy_d  = 1'b0;
            done_d  = 1'b1;
          end
          else
          begin
            beats_d  = beats_q - 3'h1;
            cnt_d    = pitch_q;
            rdy_en_d = prdy_q;
          end
        end
      end
      default: state_d = awd_idle;
    endcase
    if (sif.abort)
    begin
      state_d = awd_idle;
      busy_d  = 1'b0;
      beat_d  = 1'b0;
      done_d  = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q  <= awd_idle;
      cnt_q    <= 4'h0;
      pitch_q  <= 4'h0;
      rdy_en_q <= 1'b0;
      prdy_q   <= 1'b0;
      beats_q  <= 3'h0;
      busy_q   <= 1'b0;
      beat_q   <= 1'b0;
      done_q   <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      pitch_q  <= pitch_d;
      rdy_en_q <= rdy_en_d;
      prdy_q   <= prdy_d;
      beats_q  <= beats_d;
      busy_q   <= busy_d;
      beat_q   <= beat_d;
      done_q   <= done_d;
    end
  end

  assign sif.busy = busy_q;
  assign sif.beat = beat_q;
  assign sif.done = done_q;

  sequence s_stall;
    state_q == awd_wait && cnt_q == 4'h0 && rdy_en_q && !sif.ready_ok && !sif.abort;
  endsequence

  a_ready_extend: assert property (@(posedge aclk) disable iff (!aresetn)
    s_stall |=> !beat_q && state_q == awd_wait)
    else $error("access not extended while ready is low");

  a_count_three: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == awd_idle && sif.start && sif.first_waits == 4'h3 && !sif.first_rdy_en
     ##1 !sif.abort [*4]) |-> !beat_q ##1 beat_q)
    else $error("three waits not counted exactly");

endmodule

// ===== verification/awd_mem_model.sv
`timescale 1ns/10ps
// External memory: answers on the ready pin, stalls on command
module awd_mem_model
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Access seen by the memory
  input  wire logic       acc_busy,
  input  wire logic [4:0] hold_cycles,
  // Ready pin, pulled up while not selected
  output logic            ext_ready_n
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic       rdy_n_q;
  logic       rdy_n_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (!acc_busy)
    begin
      cnt_d = hold_cycles;
    end
    else if (cnt_q != 5'h00)
    begin
      cnt_d = cnt_q - 5'h01;
    end
    rdy_n_d = !(acc_busy && cnt_q == 5'h00);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q   <= 5'h00;
      rdy_n_q <= 1'b1;
    end
    else
    begin
      cnt_q   <= cnt_d;
      rdy_n_q <= rdy_n_d;
    end
  end

  assign ext_ready_n = rdy_n_q;
endmodule

// ===== verification/testbench.sv
`timescale 1ns/10ps
`include "awd_params.svh"
module testbench;
  logic        aclk, aresetn, manual_reset_n, ext_ready_n;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        acc_req, acc_busy, beat_strobe, acc_done;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  acc_area, acc_extra_beats;
  logic [4:0]  hold_cycles;
  int          error_cnt, total_checks, base, lat, gap, nb, lo;
  int          wt[8] = '{0, 1, 2, 3, 6, 9, 12, 15};
  int          cw[8] = '{1, 2, 3, 4, 7, 10, 13, 16};

  awd_area_wait_decode i_awd_area_wait_decode (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .acc_req(acc_req), .acc_area(acc_area), .acc_extra_beats(acc_extra_beats),
    .acc_busy(acc_busy), .beat_strobe(beat_strobe), .acc_done(acc_done),
    .ext_ready_n(ext_ready_n), .manual_reset_n(manual_reset_n));

  awd_mem_model i_awd_mem_model (
    .aclk(aclk), .aresetn(aresetn), .acc_busy(acc_busy), .hold_cycles(hold_cycles),
    .ext_ready_n(ext_ready_n));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tmo();
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    error_cnt++;
    conclude();
  endtask

  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask

  task automatic ckr(input int v, input int l, input int h);
    total_checks++;
    if (v < l || v > h)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, l, h);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    int n;
    resp = 2'bxx;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 64) tmo();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 64) tmo();
  endtask

  task automatic cfg(input logic [31:0] w, input logic [31:0] m);
    logic [1:0] rs;
    wr(`AWD_OFS_WAIT, w, rs);
    ck(32'(rs), 32'h0);
    wr(`AWD_OFS_MODE, m, rs);
    ck(32'(rs), 32'h0);
  endtask

  // One access; cycles to first beat, last beat spacing, beat count
  task automatic run(input int a, input int x, input int h, output int l, output int g,
                     output int b);
    int n;
    int last;
    l = 0;
    g = 0;
    b = 0;
    last = 0;
    @(posedge aclk);
    acc_area <= 3'(a);
    acc_extra_beats <= 3'(x);
    hold_cycles <= 5'(h);
    acc_req <= 1'b1;
    @(posedge aclk);
    acc_req <= 1'b0;
    for (n = 1; n < 120; n++)
    begin
      @(posedge aclk);
      if (beat_strobe === 1'b1)
      begin
        b++;
        g = n - last;
        last = n;
        if (l == 0) l = n;
        if (acc_done === 1'b1) break;
      end
    end
    if (n == 120) tmo();
  endtask

  initial
  begin
    error_cnt = 0;
    total_checks = 0;
    aresetn = 1'b0;
    manual_reset_n = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, acc_req} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {acc_area, acc_extra_beats, hold_cycles} = 11'h000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`AWD_OFS_WAIT, d, r);
    ck(d, 32'hfffeefff);
    rd(`AWD_OFS_MODE, d, r);
    ck(d, 32'h0);
    wr(`AWD_OFS_WAIT, 32'hffffffff, r);
    rd(`AWD_OFS_WAIT, d, r);
    ck(d, 32'hfffeefff);
    wr(8'h0c, 32'h0, r);
    ck(32'(r), 32'h2);
    rd(8'h0c, d, r);
    ck(32'(r), 32'h2);
    $display("test registers done");
    // Zero waits, ready stalled but ignored
    cfg(32'h0, 32'h0);
    run(5, 1, 31, base, gap, nb);
    ckr(base, 2, 4);
    ck(32'(nb), 32'h2);
    ck(32'(gap), 32'h1);
    for (int a = 2; a < 6; a++)
      for (int c = 0; c < 8; c++)
      begin
        lo = (a == 5) ? 23 : (a == 4) ? 17 : (a == 3) ? 13 : 9;
        cfg(32'(c) << lo, 32'h0);
        run(a, 0, (c == 0) ? 31 : 0, lat, gap, nb);
        if (c == 0 || c > 3)
          ck(32'(lat), 32'(base + wt[c]));
        else
          ckr(lat, base + wt[c], base + wt[c] + 4);
      end
    $display("test first waits done");
    for (int p = 0; p < 8; p++)
    begin
      cfg(32'(p) << 20, 32'h0);
      run(5, 3, 0, lat, gap, nb);
      ck(32'(gap), 32'(p + 1));
      ck(32'(nb), 32'h4);
    end
    $display("test burst pitch done");
    for (int a = 2; a < 4; a++)
      for (int k = 2; k < 4; k++)
        for (int c = 0; c < 8; c++)
        begin
          // Only legal latencies, row-open mode never set
          if (k == 3 && (c == 0 || c > 5)) continue;
          cfg(32'(c) << ((a == 3) ? 13 : 9), 32'(k) << ((a == 3) ? 2 : 0));
          run(a, 0, 31, lat, gap, nb);
          ck(32'(lat), 32'(base + ((k == 2) ? cw[c] - 1 : c)));
        end
    $display("test dram kinds done");
    // Multiplexed area 2, memory holds off for 20 cycles
    cfg(32'h4 << 9, 32'h1);
    run(2, 0, 20, lat, gap, nb);
    ckr(lat, 20, 60);
    // Area 3 SDRAM latency 4 with row held open is flagged
    cfg(32'h4 << 13, 32'h1c);
    rd(`AWD_OFS_STAT, d, r);
    ck(d, 32'h8);
    $display("test ready stall done");
    cfg(32'h55555555, 32'h0);
    @(posedge aclk);
    manual_reset_n <= 1'b0;
    repeat (4) @(posedge aclk);
    manual_reset_n <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`AWD_OFS_WAIT, d, r);
    ck(d, 32'h55544555);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`AWD_OFS_WAIT, d, r);
    ck(d, 32'hfffeefff);
    $display("test resets done");
    conclude();
  end
endmodule
